// ### core/bus_ctrl_arbiter.sv
// internal bus controller: cycle length by region, two-master arbitration
// assumes both masters and the sleep flag are on sys_clk
`timescale 1ns/10ps
module bus_ctrl_arbiter
	import bus_ctrl_pkg::*;
(
	input  wire logic    sys_clk,
	input  wire logic    sys_rst,
	input  wire logic    cpu_req,
	input  wire logic    cpu_lock,
	input  wire logic    cpu_sleep,
	input  wire access_t cpu_acc,
	input  wire logic    btm_req,
	input  wire logic    btm_lock,
	input  wire access_t btm_acc,
	input  wire logic    periph_path16,
	output logic         cpu_ack,
	output logic         btm_ack,
	output logic         cyc_active,
	output logic         cyc_last,
	output cycle_t       cyc_info
);

	owner_t             owner_reg;
	owner_t             owner_next;
	logic               busy_reg;
	logic               last_reg;
	logic [1:0]         remain_reg;
	cycle_t             cycle_reg;
	access_t            own_acc;
	logic               own_req;
	logic               own_lock;
	logic               boundary;
	logic               handover;
	logic               start_take;
	region_t            dec_region;
	logic [2:0]         dec_states;

	cycle_region_decode u_decode (
		.addr   (own_acc.addr),
		.region (dec_region),
		.states (dec_states)
	);

	always_comb begin
		own_acc  = (owner_reg == OWNER_BTM) ? btm_acc : cpu_acc;
		own_req  = (owner_reg == OWNER_BTM) ? btm_req : cpu_req;
		own_lock = (owner_reg == OWNER_BTM) ? btm_lock : cpu_lock;
	end

	// idle, or in the final state of the running cycle
	assign boundary = !busy_reg || last_reg;

	always_comb begin
		owner_next = owner_reg;
		unique case (owner_reg)
			OWNER_CPU: begin
				// sleeping cpu runs no cycles, so no boundary to wait for
				if (btm_req && ((boundary && !cpu_lock) || cpu_sleep))
					owner_next = OWNER_BTM;
			end
			OWNER_BTM: begin
				if (!btm_req && boundary && !btm_lock)
					owner_next = OWNER_CPU;
			end
		endcase
	end

	assign handover = (owner_next != owner_reg);

	// old owner may not open a cycle on the edge that moves the bus away
	assign start_take = own_acc.start && own_req && boundary && !handover;

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			owner_reg <= OWNER_RST;
		end else begin
			owner_reg <= owner_next;
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cpu_ack <= 1'b1;
			btm_ack <= 1'b0;
		end else begin
			cpu_ack <= (owner_next == OWNER_CPU);
			btm_ack <= (owner_next == OWNER_BTM);
		end
	end

	// state counter: reset drops any cycle without a last state
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			busy_reg   <= 1'b0;
			last_reg   <= 1'b0;
			remain_reg <= REMAIN_RST;
		end else if (start_take) begin
			busy_reg   <= 1'b1;
			last_reg   <= (dec_states == MEM_STATES);
			remain_reg <= 2'(dec_states - 3'h1);
		end else if (busy_reg) begin
			busy_reg   <= !last_reg;
			last_reg   <= (remain_reg == 2'h1);
			remain_reg <= (remain_reg == 2'h0) ? 2'h0 : 2'(remain_reg - 2'h1);
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cycle_reg <= CYCLE_RST;
		end else if (start_take) begin
			cycle_reg.addr   <= own_acc.addr;
			cycle_reg.write  <= own_acc.write;
			cycle_reg.word   <= own_acc.word;
			// memory is always 16 wide; peripherals say per register
			cycle_reg.path16 <= (dec_region == REGION_MEM) ? 1'b1 : periph_path16;
			cycle_reg.region <= dec_region;
			cycle_reg.master <= owner_reg;
		end
	end

	assign cyc_active = busy_reg;
	assign cyc_last   = last_reg;
	assign cyc_info   = cycle_reg;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	one_owner_a: assert property (cpu_ack != btm_ack)
		else $error("acknowledge not one-hot");

	mem_length_a: assert property (start_take && dec_region == REGION_MEM |=>
		cyc_active && cyc_last)
		else $error("memory cycle not one state");

	fast_length_a: assert property (start_take && dec_region == REGION_FAST |=>
		!cyc_last ##1 cyc_last)
		else $error("fast peripheral cycle not two states");

	slow_length_a: assert property (start_take && dec_region == REGION_SLOW |=>
		(cyc_active && !cyc_last) [*3] ##1 cyc_last)
		else $error("slow peripheral cycle not four states");

	cycle_end_a: assert property ($fell(cyc_active) |-> $past(cyc_last))
		else $error("cycle ended outside its last state");

	btm_priority_a: assert property (cpu_ack && btm_req && !cyc_active && !cpu_lock |=>
		btm_ack)
		else $error("block transfer request not granted at idle");

	no_preempt_a: assert property (cpu_ack && cyc_active && !cyc_last && !cpu_sleep |=>
		cpu_ack && $stable(cyc_info.master))
		else $error("bus moved inside a cycle");

	lock_hold_a: assert property (btm_ack && btm_lock |=> btm_ack)
		else $error("split access lost the bus");

	sleep_grant_a: assert property (cpu_ack && cpu_sleep && btm_req |=> btm_ack)
		else $error("sleep grant delayed");

	default_owner_a: assert property (btm_ack && !btm_req && !btm_lock && !cyc_active |=>
		cpu_ack)
		else $error("bus not returned to cpu");

	reset_clear_a: assert property ($fell(sys_rst) |-> !cyc_active && cpu_ack)
		else $error("reset left a cycle running");

	handover_c: cover property (cpu_ack && btm_req ##1 btm_ack);
	slow_cycle_c: cover property (start_take && dec_region == REGION_SLOW);
	sleep_grant_c: cover property (cpu_sleep && cpu_ack && btm_req && cyc_active);
	back_to_back_c: cover property (cyc_last && start_take);

endmodule

// ### core/bus_ctrl_pkg.sv
// bus controller package: address regions, cycle lengths, carrier types
// assumes a 24-bit internal address bus and two internal masters
package bus_ctrl_pkg;

	localparam int          ADDR_W      = 24;
	localparam int          STATE_W     = 3;
	localparam int          REMAIN_W    = 2;

	// two-state peripheral window
	localparam logic [23:0] FAST_LO     = 24'hFFFDAC;
	localparam logic [23:0] FAST_HI     = 24'hFFFFBF;
	// four-state peripheral window
	localparam logic [23:0] SLOW_LO     = 24'hFFFC30;
	localparam logic [23:0] SLOW_HI     = 24'hFFFCA3;

	// states per bus cycle, one state = one sys_clk period
	localparam logic [2:0]  MEM_STATES  = 3'h1;
	localparam logic [2:0]  FAST_STATES = 3'h2;
	localparam logic [2:0]  SLOW_STATES = 3'h4;

	localparam logic [1:0]  REMAIN_RST  = 2'h0;

	typedef enum logic [1:0] {
		REGION_MEM,
		REGION_FAST,
		REGION_SLOW
	} region_t;

	typedef enum logic {
		OWNER_CPU,
		OWNER_BTM
	} owner_t;

	localparam owner_t OWNER_RST = OWNER_CPU;

	// one access offered by a master
	typedef struct packed {
		logic              start;
		logic [23:0]       addr;
		logic              write;
		logic              word;
	} access_t;

	// the bus cycle being run
	typedef struct packed {
		logic [23:0]       addr;
		logic              write;
		logic              word;
		logic              path16;
		region_t           region;
		owner_t            master;
	} cycle_t;

	localparam cycle_t CYCLE_RST = '{addr: 24'h000000, write: 1'b0, word: 1'b0,
		path16: 1'b0, region: REGION_MEM, master: OWNER_CPU};

endpackage

// ### core/cycle_region_decode.sv
// address region decoder: picks the region and the number of states
// assumes a purely combinational use by the bus controller
`timescale 1ns/10ps
module cycle_region_decode
	import bus_ctrl_pkg::*;
(
	input  wire logic [23:0] addr,
	output region_t          region,
	output logic [2:0]       states
);

	always_comb begin
		if (addr >= FAST_LO && addr <= FAST_HI) begin
			region = REGION_FAST;
			states = FAST_STATES;
		end else if (addr >= SLOW_LO && addr <= SLOW_HI) begin
			region = REGION_SLOW;
			states = SLOW_STATES;
		end else begin
			// everything else is on-chip memory
			region = REGION_MEM;
			states = MEM_STATES;
		end
	end

endmodule

// ### testbench/btm_master_model.sv
// block transfer master model: asks for the bus when activated, runs one access
// assumes it acts on the falling edge of sys_clk
`timescale 1ns/10ps
module btm_master_model
	import bus_ctrl_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        sys_rst,
	input  wire logic        activate,
	input  wire logic [23:0] addr,
	input  wire logic        ack,
	input  wire logic        cyc_active,
	input  wire logic        cyc_last,
	input  wire cycle_t      info,
	output logic             req,
	output access_t          acc
);
	always_ff @(negedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			req <= 1'b0;
			acc <= '{start: 1'b0, addr: 24'h5A5A5A, write: 1'b0, word: 1'b0};
		end else if (activate) begin
			req <= 1'b1;
			acc <= '{start: 1'b1, addr: addr, write: 1'b1, word: 1'b1};
		end else if (acc.start && ack && cyc_active && info.master == OWNER_BTM) begin
			acc.start <= 1'b0;
			// released lines must not keep showing the address
			acc.addr <= ~acc.addr;
			req <= !cyc_last;
		end else if (!acc.start && cyc_last) begin
			req <= 1'b0;
		end
	end
endmodule

// ### testbench/bus_ctrl_arbiter_tb.sv
// self-checking bench for the bus controller and arbiter
// assumes the block transfer master model beside it
`timescale 1ns/10ps
module bus_ctrl_arbiter_tb
	import bus_ctrl_pkg::*;
;
	logic        sys_clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        cpu_req = 1'b1, cpu_lock = 1'b0, cpu_sleep = 1'b0, btm_lock = 1'b0;
	logic        periph_path16 = 1'b0, act = 1'b0;
	logic        btm_req, cpu_ack, btm_ack, cyc_active, cyc_last;
	access_t     cpu_acc = '0, btm_acc;
	cycle_t      cyc_info;
	int          miscompares = 0, check_count = 0;

	always #10 sys_clk = ~sys_clk;

	bus_ctrl_arbiter dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .cpu_req(cpu_req),
		.cpu_lock(cpu_lock), .cpu_sleep(cpu_sleep), .cpu_acc(cpu_acc), .btm_req(btm_req),
		.btm_lock(btm_lock), .btm_acc(btm_acc), .periph_path16(periph_path16),
		.cpu_ack(cpu_ack), .btm_ack(btm_ack), .cyc_active(cyc_active),
		.cyc_last(cyc_last), .cyc_info(cyc_info));
	btm_master_model btm (.sys_clk(sys_clk), .sys_rst(sys_rst), .activate(act),
		.addr(24'h000200), .ack(btm_ack), .cyc_active(cyc_active), .cyc_last(cyc_last),
		.info(cyc_info), .req(btm_req), .acc(btm_acc));

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %0t: saw %0h expected %0h", $time, seen, exp);
		end
	endtask

	task report_and_stop;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// n = states from first active state to cyc_last, 0 if never taken
	task cpu_go(input logic [23:0] a, output logic [31:0] n);
		cpu_acc = '{start: 1'b1, addr: a, write: 1'b0, word: 1'b1};
		n = 0;
		for (int k = 0; k < 20 && n == 0; k++) begin
			@(negedge sys_clk);
			if (cyc_active && cyc_info.master === OWNER_CPU && cyc_info.addr === a)
				n = 1;
		end
		cpu_acc.start = 1'b0;
		for (int k = 0; k < 8 && n != 0 && !cyc_last; k++) begin
			@(negedge sys_clk);
			n++;
		end
	endtask

	task activate;
		act <= 1'b1;
		@(negedge sys_clk);
		act <= 1'b0;
	endtask

	task t_len;
		logic [23:0] a [7] = '{24'h000100, 24'hFFFDAC, 24'hFFFFBF, 24'hFFFC30,
			24'hFFFCA3, 24'hFFFC2F, 24'hFFFFC0};
		logic [31:0] s [7] = '{1, 2, 2, 4, 4, 1, 1};
		logic [31:0] n;
		for (int i = 0; i < 7; i++) begin
			periph_path16 = i[0];
			cpu_go(a[i], n);
			chk(n, s[i]);
			chk(cyc_info.path16, (s[i] == 1) ? 1'b1 : i[0]);
			chk(cyc_info.region, (s[i] == 1) ? REGION_MEM :
				(s[i] == 2) ? REGION_FAST : REGION_SLOW);
			chk({cyc_info.write, cyc_info.word}, 2'h1);
			@(negedge sys_clk);
		end
		$display("test lengths done");
	endtask

	task t_prio;
		cpu_acc = '{start: 1'b1, addr: 24'hFFFC40, write: 1'b1, word: 1'b0};
		@(negedge sys_clk);
		cpu_acc.start = 1'b0;
		activate;
		repeat (2) @(negedge sys_clk);
		chk(cpu_ack, 1'b1);
		@(negedge sys_clk);
		chk(btm_ack, 1'b1);
		@(negedge sys_clk);
		chk(cyc_info.master, OWNER_BTM);
		chk({cyc_info.write, cyc_info.word}, 2'h3);
		@(negedge sys_clk);
		chk(cpu_ack, 1'b1);
		$display("test priority done");
	endtask

	task t_lock;
		cpu_lock = 1'b1;
		activate;
		repeat (4) @(negedge sys_clk);
		chk(cpu_ack, 1'b1);
		cpu_lock = 1'b0;
		@(negedge sys_clk);
		chk(btm_ack, 1'b1);
		cpu_lock = 1'b1;
		cpu_sleep = 1'b1;
		repeat (2) @(negedge sys_clk);
		activate;
		@(negedge sys_clk);
		chk(btm_ack, 1'b1);
		cpu_lock = 1'b0;
		cpu_sleep = 1'b0;
		btm_lock = 1'b1;
		repeat (2) @(negedge sys_clk);
		chk(btm_ack, 1'b1);
		btm_lock = 1'b0;
		@(negedge sys_clk);
		chk(cpu_ack, 1'b1);
		$display("test lock and sleep done");
	endtask

	task t_abort;
		cpu_acc = '{start: 1'b1, addr: 24'hFFFC60, write: 1'b0, word: 1'b0};
		repeat (2) @(negedge sys_clk);
		cpu_acc.start = 1'b0;
		sys_rst = 1'b1;
		#1;
		chk(cyc_active, 1'b0);
		chk(cyc_info, CYCLE_RST);
		@(negedge sys_clk);
		sys_rst = 1'b0;
		repeat (3) @(negedge sys_clk);
		chk({cyc_last, cyc_active, cpu_ack}, 3'h1);
		cpu_req = 1'b0;
		cpu_acc.start = 1'b1;
		repeat (2) @(negedge sys_clk);
		chk(cyc_active, 1'b0);
		cpu_req = 1'b1;
		@(negedge sys_clk);
		chk(cyc_active, 1'b1);
		cpu_acc.start = 1'b0;
		$display("test abort done");
	endtask

	initial begin
		repeat (3) @(negedge sys_clk);
		sys_rst = 1'b0;
		chk({cpu_ack, btm_ack, cyc_active}, 3'h4);
		t_len;
		t_prio;
		t_lock;
		t_abort;
		report_and_stop;
	end

	// whole run is under a hundred cycles
	initial begin
		#40000;
		miscompares++;
		report_and_stop;
	end
endmodule
